/* File: core/aitp_axis.v */
// Functional notes
// - encoder inputs one clock, filtered three
// - manual pulse one clock, filtered three
// - sensor inputs two clocks, filtered eighty
// - jog inputs two clocks, filtered 655360
// - clear pulse width by code times 254
// - code 111 gives level clear output
// - encoder up/down or quadrature mode
// - manual pulse up/down or quadrature mode
// - busy 5/7, first pulse 15/17 clocks
// - command 24h starts clear output
// - command 25h ends clear output
`include "aitp_defines.vh"
module aitp_axis (
	input  wire        SYS_CLK_I,
	input  wire        RESET_N_I,
	input  wire [3:0]  AVS_ADDRESS_I,
	input  wire        AVS_READ_I,
	input  wire        AVS_WRITE_I,
	input  wire [31:0] AVS_WRITEDATA_I,
	output reg  [31:0] AVS_READDATA_O,
	output reg         AVS_WAITREQUEST_O,
	input  wire        ENCODER_PHASE_A_I,
	input  wire        ENCODER_PHASE_B_I,
	input  wire        ENCODER_INDEX_I,
	input  wire        MANUAL_PULSE_A_I,
	input  wire        MANUAL_PULSE_B_I,
	input  wire        SERVO_ALARM_I,
	input  wire        IN_POSITION_I,
	input  wire [1:0]  END_LIMIT_I,
	input  wire        SLOWDOWN_I,
	input  wire        ORIGIN_I,
	input  wire [1:0]  JOG_DIRECTION_I,
	input  wire        JOG_ENABLE_N_I,
	input  wire        SYNC_START_N_I,
	output reg         BUSY_N_O,
	output reg         PULSE_O,
	output reg         DEVIATION_CLEAR_O,
	output reg         IRQ_O
);
	// filter lengths per group
	reg [31:0] env1_reg;
	reg [31:0] env2_reg;
	reg [7:0]  status_reg;
	reg [7:0]  irq_en_reg;
	reg [15:0] enc_cnt_reg;
	reg [15:0] mpg_cnt_reg;
	wire [19:0] len_enc  = env2_reg[`AITP_ENC_FLT_BIT] ?
		20'd3 : 20'd1;
	wire [19:0] len_mpg  = env2_reg[`AITP_MPG_FLT_BIT] ?
		20'd3 : 20'd1;
	wire [19:0] len_sens = env1_reg[`AITP_SENS_FLT_BIT] ?
		20'd80 : 20'd2;
	wire [19:0] len_jog  = env1_reg[`AITP_JOG_FLT_BIT] ?
		20'd655360 : 20'd2;

	// all filtered inputs, one filter instance each
	// low-active lines inverted so the idle level matches reset
	wire [14:0] raw_in = {~SYNC_START_N_I, ~JOG_ENABLE_N_I,
		JOG_DIRECTION_I,
		ORIGIN_I, SLOWDOWN_I, END_LIMIT_I, IN_POSITION_I, SERVO_ALARM_I,
		MANUAL_PULSE_B_I, MANUAL_PULSE_A_I, ENCODER_INDEX_I,
		ENCODER_PHASE_B_I, ENCODER_PHASE_A_I};
	wire [14:0] flt;
	genvar gi;
	generate
		for (gi = 0; gi < 15; gi = gi + 1) begin : g_flt
			wire [19:0] len_sel = (gi < 3) ? len_enc :
				(gi < 5) ? len_mpg : (gi < 11) ? len_sens :
				(gi < 14) ? len_jog : 20'd1;
			aitp_filter u_flt (
				.clk_i   (SYS_CLK_I),
				.rst_n_i (RESET_N_I),
				.raw_i   (raw_in[gi]),
				.len_i   (len_sel),
				.out_o   (flt[gi])
			);
		end
	endgenerate

	// count direction decode for up/down or quadrature
	function [1:0] step_dec;
		input       quad;
		input [1:0] now_ab;
		input [1:0] old_ab;
		begin
			step_dec = 2'b00;
			if (quad) begin
				if (now_ab != old_ab && (now_ab ^ old_ab) != 2'b11)
					step_dec = ((old_ab[0] ^ now_ab[1]) ? 2'b01 : 2'b10);
			end else begin
				if (now_ab[0] & ~old_ab[0])
					step_dec = 2'b01;
				else if (now_ab[1] & ~old_ab[1])
					step_dec = 2'b10;
			end
		end
	endfunction

	reg [1:0] enc_old_reg;
	reg [1:0] mpg_old_reg;
	reg       sta_old_reg;
	wire [1:0] enc_step = step_dec(env2_reg[`AITP_ENC_MODE_BIT],
		flt[1:0], enc_old_reg);
	wire [1:0] mpg_step = step_dec(env2_reg[`AITP_MPG_MODE_BIT],
		flt[4:3], mpg_old_reg);
	wire sta_fall = ~sta_old_reg & flt[14]; // pin fell, seen inverted

	// bus decode
	wire       wr_go  = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
	wire       rd_ld  = AVS_READ_I & AVS_WAITREQUEST_O;
	wire       cmd_wr = wr_go && AVS_ADDRESS_I == `AITP_ADDR_CMD;
	wire [7:0] cmd    = AVS_WRITEDATA_I[7:0];

	// clear pulse timer and start sequencing
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_RUN  = 2'b10;
	reg [1:0]  st_reg;
	reg [7:0]  dly_reg;
	reg [21:0] erc_cnt_reg;
	reg        erc_lvl_reg;
	wire [2:0] erc_code = env1_reg[`AITP_ERC_MSB:`AITP_ERC_LSB];
	reg  [21:0] erc_len;
	always @* begin
		case (erc_code)
			3'b000:  erc_len = 22'd254;
			3'b001:  erc_len = 22'd254 * 22'd8;
			3'b010:  erc_len = 22'd254 * 22'd32;
			3'b011:  erc_len = 22'd254 * 22'd128;
			3'b100:  erc_len = 22'd254 * 22'd1024;
			3'b101:  erc_len = 22'd254 * 22'd4096;
			3'b110:  erc_len = 22'd254 * 22'd8192;
			default: erc_len = 22'd0;
		endcase
	end

	wire [7:0] ev = {3'b000, sta_fall, 1'b0,
		|enc_step, st_reg == ST_RUN, DEVIATION_CLEAR_O};

	// registers, bus, sequencing
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			env1_reg          <= `AITP_ENV1_RST;
			env2_reg          <= `AITP_ENV2_RST;
			status_reg        <= 8'h00;
			irq_en_reg        <= 8'h00;
			enc_cnt_reg       <= 16'h0000;
			mpg_cnt_reg       <= 16'h0000;
			enc_old_reg       <= 2'b00;
			mpg_old_reg       <= 2'b00;
			sta_old_reg       <= 1'b0;
			st_reg            <= ST_IDLE;
			dly_reg           <= 8'h00;
			erc_cnt_reg       <= 22'h000000;
			erc_lvl_reg       <= 1'b0;
			AVS_READDATA_O    <= 32'h00000000;
			AVS_WAITREQUEST_O <= 1'b1;
			BUSY_N_O          <= 1'b1;
			PULSE_O           <= 1'b0;
			DEVIATION_CLEAR_O <= 1'b0;
			IRQ_O             <= 1'b0;
		end else begin
			enc_old_reg <= flt[1:0];
			mpg_old_reg <= flt[4:3];
			sta_old_reg <= flt[14];
			if (enc_step == 2'b01) enc_cnt_reg <= enc_cnt_reg + 16'h0001;
			if (enc_step == 2'b10) enc_cnt_reg <= enc_cnt_reg - 16'h0001;
			if (mpg_step == 2'b01) mpg_cnt_reg <= mpg_cnt_reg + 16'h0001;
			if (mpg_step == 2'b10) mpg_cnt_reg <= mpg_cnt_reg - 16'h0001;
			// one wait cycle per access
			AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) &
				AVS_WAITREQUEST_O);
			if (wr_go && AVS_ADDRESS_I == `AITP_ADDR_ENV1)
				env1_reg <= AVS_WRITEDATA_I;
			if (wr_go && AVS_ADDRESS_I == `AITP_ADDR_ENV2)
				env2_reg <= AVS_WRITEDATA_I;
			if (wr_go && AVS_ADDRESS_I == `AITP_ADDR_IRQ_EN)
				irq_en_reg <= AVS_WRITEDATA_I[7:0];
			// set wins over clear
			status_reg <= (status_reg & ~((wr_go &&
				AVS_ADDRESS_I == `AITP_ADDR_IRQ_CLR) ?
				AVS_WRITEDATA_I[7:0] : 8'h00)) | ev;
			IRQ_O <= |(status_reg & irq_en_reg);
			// load in the wait cycle so data stand at the taking edge
			if (rd_ld) begin
				case (AVS_ADDRESS_I)
					`AITP_ADDR_ENV1:    AVS_READDATA_O <= env1_reg;
					`AITP_ADDR_ENV2:    AVS_READDATA_O <= env2_reg;
					`AITP_ADDR_STATUS:  AVS_READDATA_O <= {24'h0, status_reg};
					`AITP_ADDR_IRQ_EN:  AVS_READDATA_O <= {24'h0, irq_en_reg};
					`AITP_ADDR_ENC_CNT: AVS_READDATA_O <= {16'h0, enc_cnt_reg};
					`AITP_ADDR_MPG_CNT: AVS_READDATA_O <= {16'h0, mpg_cnt_reg};
					`AITP_ADDR_INPUTS:  AVS_READDATA_O <= {17'h0, flt};
					default:            AVS_READDATA_O <= 32'h00000000;
				endcase
			end
			// clear output: timed pulse or level
			if (cmd_wr && cmd == `AITP_CMD_ERC_CLR) begin
				DEVIATION_CLEAR_O <= 1'b0;
				erc_lvl_reg       <= 1'b0;
				erc_cnt_reg       <= 22'h000000;
			end else if (cmd_wr && cmd == `AITP_CMD_ERC_SET) begin
				DEVIATION_CLEAR_O <= 1'b1;
				erc_lvl_reg       <= (erc_code == 3'b111);
				erc_cnt_reg       <= erc_len;
			end else if (DEVIATION_CLEAR_O && !erc_lvl_reg) begin
				if (erc_cnt_reg <= 22'h000001)
					DEVIATION_CLEAR_O <= 1'b0;
				erc_cnt_reg <= erc_cnt_reg - 22'h000001;
			end
			// start: busy next cycle, pulse after fixed delay
			PULSE_O <= 1'b0;
			case (st_reg)
				ST_IDLE: begin
					if (cmd_wr && cmd == `AITP_CMD_START) begin
						BUSY_N_O <= 1'b0;
						dly_reg  <= `AITP_PLS_CMD_DLY;
						st_reg   <= ST_WAIT;
					end else if (sta_fall) begin
						BUSY_N_O <= 1'b0;
						dly_reg  <= `AITP_PLS_STA_DLY;
						st_reg   <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					dly_reg <= dly_reg - 8'h01;
					if (dly_reg == 8'h01) begin
						PULSE_O <= 1'b1;
						st_reg  <= ST_RUN;
					end
				end
				ST_RUN: begin
					BUSY_N_O <= 1'b1;
					st_reg   <= ST_IDLE;
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

/* File: core/aitp_defines.vh */
`ifndef AITP_DEFINES_VH
`define AITP_DEFINES_VH
// register word addresses, one 32-bit register each
`define AITP_ADDR_ENV1      4'h0
`define AITP_ADDR_ENV2      4'h1
`define AITP_ADDR_CMD       4'h2
`define AITP_ADDR_STATUS    4'h3
`define AITP_ADDR_IRQ_CLR   4'h4
`define AITP_ADDR_IRQ_EN    4'h5
`define AITP_ADDR_ENC_CNT   4'h6
`define AITP_ADDR_MPG_CNT   4'h7
`define AITP_ADDR_INPUTS    4'h8
// field positions
`define AITP_ERC_LSB        12
`define AITP_ERC_MSB        14
`define AITP_SENS_FLT_BIT   26
`define AITP_JOG_FLT_BIT    27
`define AITP_ENC_FLT_BIT    18
`define AITP_MPG_FLT_BIT    19
`define AITP_ENC_MODE_BIT   0
`define AITP_MPG_MODE_BIT   1
// reset values
`define AITP_ENV1_RST       32'h00000000
`define AITP_ENV2_RST       32'h00000000
// commands
`define AITP_CMD_ERC_SET    8'h24
`define AITP_CMD_ERC_CLR    8'h25
`define AITP_CMD_START      8'h50
// timing counts in clocks
`define AITP_RESET_MIN      10
`define AITP_ENC_FLT_CYC    3
`define AITP_SENS_MIN       2
`define AITP_SENS_FLT_CYC   80
`define AITP_JOG_FLT_CYC    655360
`define AITP_ERC_BASE       254
`define AITP_BSY_CMD_MAX    5
`define AITP_BSY_STA_MAX    7
`define AITP_PLS_CMD_MAX    15
`define AITP_PLS_STA_MAX    17
`define AITP_PLS_CMD_DLY    8'd12
`define AITP_PLS_STA_DLY    8'd14
`endif

/* File: core/aitp_filter.v */
`include "aitp_defines.vh"
// stability filter: passes a new level after it held len cycles
module aitp_filter (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        raw_i,
	input  wire [19:0] len_i,
	output reg         out_o
);
	reg [19:0] cnt_reg;
	reg        prev_reg;
	// run length including this sample, held at full scale
	wire [19:0] run = (raw_i != prev_reg) ? 20'h00001 :
		(cnt_reg == 20'hFFFFF) ? cnt_reg : cnt_reg + 20'h00001;

	// count consecutive samples equal to the last raw level
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg  <= 20'h00000;
			prev_reg <= 1'b0;
			out_o    <= 1'b0;
		end else begin
			prev_reg <= raw_i;
			cnt_reg  <= run;
			// a one-clock filter passes every sample
			if (run >= len_i)
				out_o <= raw_i;
		end
	end
endmodule

/* File: verification/aitp_axis_asserts.sv */
module aitp_chk (
	input logic        SYS_CLK_I,
	input logic        RESET_N_I,
	input logic [3:0]  AVS_ADDRESS_I,
	input logic        AVS_WRITE_I,
	input logic [31:0] AVS_WRITEDATA_I,
	input logic        AVS_WAITREQUEST_O,
	input logic        SYNC_START_N_I,
	input logic        BUSY_N_O,
	input logic        PULSE_O,
	input logic        DEVIATION_CLEAR_O
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SH [8] = '{0, 3, 5, 7, 10, 12, 13, 0};
	logic [2:0]  code_reg;
	logic [21:0] hi_reg;
	logic        kill_reg;
	wire         tk = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	wire         cmd = tk && AVS_ADDRESS_I == 4'h2;
	wire  [7:0]  op = AVS_WRITEDATA_I[7:0];
	wire  [21:0] m = 22'h1 << SH[code_reg];
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// width code copy, high-time count, release seen
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			code_reg <= 3'h0;
			hi_reg   <= 22'h0;
			kill_reg <= 1'b0;
		end else begin
			hi_reg <= DEVIATION_CLEAR_O ? hi_reg + 22'h1 : 22'h0;
			if (tk && AVS_ADDRESS_I == 4'h0)
				code_reg <= AVS_WRITEDATA_I[14:12];
			if (cmd)
				kill_reg <= op == 8'h25;
		end
	end
	// starts that an idle axis must honour
	sequence s_cmd;
		cmd && op == 8'h50 && BUSY_N_O;
	endsequence
	sequence s_pin;
		$fell(SYNC_START_N_I) && BUSY_N_O;
	endsequence
	AST_CMD_BUSY: assert property (s_cmd |-> ##[1:5] !BUSY_N_O)
		else $error("busy late");
	AST_CMD_PULSE: assert property (s_cmd |-> ##[1:15] PULSE_O)
		else $error("pulse late");
	AST_PIN_BUSY: assert property (s_pin |-> ##[1:7] !BUSY_N_O)
		else $error("pin busy late");
	AST_PIN_PULSE: assert property (s_pin |-> ##[1:17] PULSE_O)
		else $error("pin pulse late");
	AST_PULSE_BUSY: assert property (
		PULSE_O |-> !BUSY_N_O ##1 !PULSE_O) else $error("pulse off busy");
	AST_CLR_ON: assert property (
		cmd && op == 8'h24 |-> ##[1:2] DEVIATION_CLEAR_O)
		else $error("clear not driven");
	AST_CLR_OFF: assert property (
		cmd && op == 8'h25 |-> ##[1:2] !DEVIATION_CLEAR_O)
		else $error("clear not released");
	AST_CLR_WIDTH: assert property (
		$fell(DEVIATION_CLEAR_O) && !kill_reg |-> code_reg != 3'h7
		&& hi_reg >= 254 * m && hi_reg <= 255 * m)
		else $error("clear width wrong");
endmodule

bind aitp_axis aitp_chk chk_u (.SYS_CLK_I, .RESET_N_I, .AVS_ADDRESS_I,
	.AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_WAITREQUEST_O, .SYNC_START_N_I,
	.BUSY_N_O, .PULSE_O, .DEVIATION_CLEAR_O);

/* File: verification/aitp_far_model.sv */
module aitp_far_model (
	input  logic       clk_i,
	output logic [1:0] ab_o,
	output logic [8:0] sens_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle encoder lines, jog enable off
	initial begin
		ab_o   = 2'h0;
		sens_o = 9'h100;
	end
	// one pulse on a (up) or b (down), w wide and w apart
	task automatic pulse(input int line, input int w);
		@(posedge clk_i);
		ab_o[line] <= 1'b1;
		repeat (w) @(posedge clk_i);
		ab_o[line] <= 1'b0;
		repeat (w) @(posedge clk_i);
	endtask
	// one quadrature cycle, forward or back
	task automatic quad(input logic fwd);
		logic [1:0] g [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			ab_o <= fwd ? g[i] : g[(6 - i) % 4];
			@(posedge clk_i);
		end
	endtask
	// sensor and jog levels, held for n cycles
	task automatic level(input logic [8:0] v, input int n);
		@(posedge clk_i);
		sens_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
endmodule

/* File: verification/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SH [8] = '{0, 3, 5, 7, 10, 12, 13, 0};
	logic        clk = 0, rst_n = 0, rd = 0, wr = 0, sync_n = 1;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, rdata, q;
	logic [1:0]  ab;
	logic [8:0]  sens;
	logic        wait_r, busy_n, pls, dclr, irq;
	int          n_errors = 0, checks = 0, cyc = 0, npls = 0, n;
	always #20 clk = ~clk;
	aitp_far_model far_u (.clk_i(clk), .ab_o(ab), .sens_o(sens));
	aitp_axis dut_u (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_r), .ENCODER_PHASE_A_I(ab[0]),
		.ENCODER_PHASE_B_I(ab[1]), .ENCODER_INDEX_I(ab[0] & ab[1]),
		.MANUAL_PULSE_A_I(ab[0]), .MANUAL_PULSE_B_I(ab[1]),
		.SERVO_ALARM_I(sens[0]), .IN_POSITION_I(sens[1]),
		.END_LIMIT_I(sens[3:2]), .SLOWDOWN_I(sens[4]), .ORIGIN_I(sens[5]),
		.JOG_DIRECTION_I(sens[7:6]), .JOG_ENABLE_N_I(sens[8]),
		.SYNC_START_N_I(sync_n), .BUSY_N_O(busy_n), .PULSE_O(pls),
		.DEVIATION_CLEAR_O(dclr), .IRQ_O(irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wait_r !== 1'b0 && k < 50);
		chk(32'(wait_r), 32'h0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// output pulse tally and run limit
	always @(posedge clk) begin
		npls <= npls + int'(pls === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdc(4'h0, 32'h0);
		rdc(4'h1, 32'h0);
		bus(1'b1, 4'hF, 32'hFFFFFFFF);
		rdc(4'hF, 32'h0);
		// command start, second one refused while busy
		bus(1'b1, 4'h5, 32'h2);
		bus(1'b1, 4'h2, 32'h50);
		bus(1'b1, 4'h2, 32'h50);
		repeat (40) @(posedge clk);
		chk(32'(npls), 32'h1);
		chk(32'(irq), 32'h1);
		rdc(4'h3, 32'h2);
		bus(1'b1, 4'h5, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		bus(1'b1, 4'h4, 32'h2);
		rdc(4'h3, 32'h0);
		// start from the sync line
		@(posedge clk);
		sync_n <= 1'b0;
		repeat (5) @(posedge clk);
		sync_n <= 1'b1;
		repeat (40) @(posedge clk);
		chk(32'(npls), 32'h2);
		rdc(4'h3, 32'h12);
		// every clear width code, long ones cut short
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, 4'h0, 32'(c) << 12);
			bus(1'b1, 4'h2, 32'h24);
			n = 0;
			@(posedge clk);
			while (dclr === 1'b1 && n < (c < 4 ? 40000 : 3000)) begin
				n++;
				@(posedge clk);
			end
			if (c < 4)
				chk(32'(n >= 254 << SH[c] && n <= 255 << SH[c]), 32'h1);
			else
				chk(32'(n), 32'd3000);
			bus(1'b1, 4'h2, 32'h25);
			repeat (2) @(posedge clk);
			chk(32'(dclr), 32'h0);
		end
		// up/down counting, then filter drops short pulses
		repeat (3) far_u.pulse(0, 1);
		far_u.pulse(1, 1);
		repeat (4) @(posedge clk);
		rdc(4'h6, 32'h2);
		rdc(4'h7, 32'h2);
		bus(1'b1, 4'h1, 32'h000C0000);
		far_u.pulse(0, 2);
		far_u.pulse(0, 3);
		repeat (4) @(posedge clk);
		rdc(4'h6, 32'h3);
		rdc(4'h7, 32'h3);
		// quadrature forward then back
		bus(1'b1, 4'h1, 32'h3);
		far_u.quad(1'b1);
		repeat (4) @(posedge clk);
		bus(1'b0, 4'h6, 32'h0);
		chk(32'(q == 32'h7 || q == 32'h0000FFFF), 32'h1);
		far_u.quad(1'b0);
		repeat (4) @(posedge clk);
		rdc(4'h6, 32'h3);
		rdc(4'h7, 32'h3);
		// filtered sensor levels reach the input image
		bus(1'b1, 4'h0, 32'h04000000);
		rdc(4'h8, 32'h0);
		far_u.level(9'h0FF, 40);
		rdc(4'h8, 32'h00003800);
		far_u.level(9'h0FF, 100);
		rdc(4'h8, 32'h00003FE0);
		tally_and_finish();
	end
endmodule
